/* File: common/viu_pkg.sv */
// constants, register offsets and state types of the vectored interrupt unit
package viu_pkg;
    localparam int NUM_SRC = 32;
    localparam int PRIO_W = 4;
    localparam int ADDR_W = 12;
    localparam logic [4:0] EXT3_CH = 5'h11;
    localparam logic [11:0] OFS_RAW_STAT = 12'h000;
    localparam logic [11:0] OFS_ENABLE = 12'h004;
    localparam logic [11:0] OFS_SELECT = 12'h008;
    localparam logic [11:0] OFS_FAST_STAT = 12'h00C;
    localparam logic [11:0] OFS_NORM_STAT = 12'h010;
    localparam logic [11:0] OFS_VECT_ADDR = 12'h014;
    localparam logic [11:0] OFS_P0_RISE = 12'h01C;
    localparam logic [11:0] OFS_P0_FALL = 12'h020;
    localparam logic [11:0] OFS_P2_RISE = 12'h024;
    localparam logic [11:0] OFS_P2_FALL = 12'h028;
    localparam logic [11:0] OFS_P0_EDGE = 12'h02C;
    localparam logic [11:0] OFS_P2_EDGE = 12'h030;
    localparam logic [11:0] OFS_EVT_STAT = 12'h034;
    localparam logic [11:0] OFS_EVT_MASK = 12'h038;
    localparam logic [4:0] REGION_VECT = 5'h02;
    localparam logic [4:0] REGION_PRIO = 5'h04;
    localparam int EVT_FAST = 0;
    localparam int EVT_NORM = 1;
    localparam int EVT_EDGE = 2;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [3:0] PRIO_RST = 4'hF;
    localparam logic [2:0] EVT_RST = 3'h0;

    typedef struct packed {
        logic [31:0] enable;
        logic [31:0] select;
        logic [31:0][3:0] prio;
        logic [31:0] rise0;
        logic [31:0] fall0;
        logic [31:0] rise2;
        logic [31:0] fall2;
        logic [31:0] prev0;
        logic [31:0] prev2;
        logic [31:0] edge0;
        logic [31:0] edge2;
        logic primed;
        logic fast;
        logic norm;
        logic [4:0] win_idx;
        logic win_vld;
        logic vld_p;
        logic [31:0] vect;
        logic [2:0] evt_stat;
        logic [2:0] evt_mask;
        logic evt_irq;
        logic [31:0] rdata;
    } viu_state_s;

    typedef struct packed {
        logic [31:0][31:0] words;
        logic [31:0] rdata;
    } viu_mem_s;
endpackage : viu_pkg

/* File: common/viu_mem_if.sv */
// write and read path between the core and its handler address table
`timescale 1ns/1ps
`default_nettype none
interface viu_mem_if;
    logic we;
    logic [4:0] waddr;
    logic [31:0] wdata;
    logic [4:0] raddr;
    logic [31:0] rdata;
    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : viu_mem_if
`default_nettype wire

/* File: hdl/viu_vect_mem.sv */
// handler address table, 32 words, registered read data
`timescale 1ns/1ps
`default_nettype none
module viu_vect_mem (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    viu_mem_if.mem port // table access
);
    viu_pkg::viu_mem_s st_q;
    viu_pkg::viu_mem_s st_d;

    always_comb
    begin
        st_d = st_q;
        if (port.we)
        begin
            st_d.words[port.waddr] = port.wdata;
        end
        st_d.rdata = st_q.words[port.raddr];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign port.rdata = st_q.rdata;
endmodule : viu_vect_mem
`default_nettype wire

/* File: hdl/viu_vectored_interrupt_unit.sv */
// vectored interrupt unit: fast and vectored classes, port 0/2 edge capture, register port
//
// Notes on behaviour
// RL1 - There are 32 request inputs and each is set to the fast or the vectored class by a select bit.
// RL2 - Fast requests outrank every vectored request, so a fast channel never wins vectored selection.
// RL3 - The fast output is the OR of all enabled active requests in the fast class.
// RL4 - A readable word shows which fast class sources are requesting now.
// RL5 - Every other request is vectored, with a priority software can rewrite at any time.
// RL6 - Among pending vectored requests of equal priority the lowest channel number wins.
// RL7 - The normal output is the OR of all enabled active requests in the vectored class.
// RL8 - A readable register returns the handler address of the winning vectored request.
// RL9 - Each peripheral drives one request line, which may combine several of its flags.
// RL10 - Each of the 64 pins of ports 0 and 2 can raise a request on rising, falling or both edges.
// RL11 - Port 0 and port 2 edge requests are merged into the third external interrupt channel.
// RL12 - Requests are levels and the fast and normal outputs stay high while a contributing request stays active and enabled.
`timescale 1ns/1ps
`default_nettype none
module viu_vectored_interrupt_unit (
    input wire logic CLK_SYS, // 125 MHz system clock
    input wire logic RST, // synchronous reset, active high
    input wire logic [11:0] ADDR, // register byte address
    input wire logic [31:0] WDATA, // write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    output logic [31:0] RDATA, // read data, cycle after RD
    input wire logic [31:0] IRQ_SRC, // peripheral request levels
    input wire logic EXT_INTERRUPT_LINE_THREE, // external interrupt 3 pin request level
    input wire logic [31:0] GPIO0, // port 0 pin levels
    input wire logic [31:0] GPIO2, // port 2 pin levels
    output logic FAST_INTERRUPT_REQUEST, // fast request to core
    output logic IRQ_OUT, // normal request to core
    output logic EVT_IRQ // event summary interrupt
);
    viu_pkg::viu_state_s st_q;
    viu_pkg::viu_state_s st_d;
    viu_mem_if mem_bus ();

    logic [31:0] req;
    logic [31:0] act;
    logic [31:0] hit0;
    logic [31:0] hit2;
    logic [31:0] fast_act;
    logic [31:0] tie_cand;
    logic [31:0] better;
    logic [3:0] win_prio;
    logic [4:0] win_idx;
    logic win_vld;
    logic rd_stat;

    viu_vect_mem u_mem (
        .clk(CLK_SYS),
        .rst(RST),
        .port(mem_bus.mem)
    );

    // edges only count after one sampled cycle, so levels present at reset release do not fire
    assign hit0 = st_q.primed ? ((GPIO0 & ~st_q.prev0 & st_q.rise0) | (~GPIO0 & st_q.prev0 & st_q.fall0)) : '0; // RL10
    assign hit2 = st_q.primed ? ((GPIO2 & ~st_q.prev2 & st_q.rise2) | (~GPIO2 & st_q.prev2 & st_q.fall2)) : '0; // RL10

    always_comb
    begin
        req = IRQ_SRC;
        req[viu_pkg::EXT3_CH] = EXT_INTERRUPT_LINE_THREE | (|st_q.edge0) | (|st_q.edge2); // RL11
    end

    assign fast_act = req & st_q.enable & st_q.select; // RL3 RL12
    assign act = req & st_q.enable & ~st_q.select; // RL2 RL5 RL12

    // strict compare keeps the lowest channel among equals
    always_comb
    begin
        win_prio = viu_pkg::PRIO_RST;
        win_idx = '0;
        win_vld = 1'b0;
        for (int i = 0; i < viu_pkg::NUM_SRC; i++)
        begin
            if (act[i] && (!win_vld || st_q.prio[i] < win_prio)) // RL6
            begin
                win_prio = st_q.prio[i];
                win_idx = 5'(i);
                win_vld = 1'b1;
            end
        end
    end

    // per channel view of the winner, used by the checks below
    for (genvar g = 0; g < viu_pkg::NUM_SRC; g++)
    begin : g_chan
        assign tie_cand[g] = act[g] && (st_q.prio[g] == win_prio);
        assign better[g] = act[g] && (st_q.prio[g] < win_prio);
    end

    assign rd_stat = RD && (ADDR == viu_pkg::OFS_EVT_STAT);
    assign mem_bus.we = WR && (ADDR[11:7] == viu_pkg::REGION_VECT);
    assign mem_bus.waddr = ADDR[6:2];
    assign mem_bus.wdata = WDATA;
    assign mem_bus.raddr = st_q.win_idx;

    always_comb
    begin
        st_d = st_q;
        st_d.primed = 1'b1;
        st_d.prev0 = GPIO0;
        st_d.prev2 = GPIO2;
        st_d.fast = |fast_act; // RL3
        st_d.norm = |act; // RL7
        st_d.win_idx = win_idx; // RL5
        st_d.win_vld = win_vld;
        st_d.vld_p = st_q.win_vld;
        st_d.vect = st_q.vld_p ? mem_bus.rdata : viu_pkg::WORD_RST; // RL8
        st_d.rdata = viu_pkg::WORD_RST;
        if (WR)
        begin
            case (ADDR)
                viu_pkg::OFS_ENABLE: st_d.enable = WDATA;
                viu_pkg::OFS_SELECT: st_d.select = WDATA; // RL1
                viu_pkg::OFS_P0_RISE: st_d.rise0 = WDATA; // RL10
                viu_pkg::OFS_P0_FALL: st_d.fall0 = WDATA;
                viu_pkg::OFS_P2_RISE: st_d.rise2 = WDATA;
                viu_pkg::OFS_P2_FALL: st_d.fall2 = WDATA;
                viu_pkg::OFS_P0_EDGE: st_d.edge0 = st_q.edge0 & ~WDATA;
                viu_pkg::OFS_P2_EDGE: st_d.edge2 = st_q.edge2 & ~WDATA;
                viu_pkg::OFS_EVT_MASK: st_d.evt_mask = WDATA[2:0];
                default:
                begin
                    if (ADDR[11:7] == viu_pkg::REGION_PRIO)
                    begin
                        st_d.prio[ADDR[6:2]] = WDATA[3:0]; // RL5
                    end
                end
            endcase
        end
        // a new edge in the cycle of its clear still lands
        st_d.edge0 = st_d.edge0 | hit0; // RL10
        st_d.edge2 = st_d.edge2 | hit2;
        if (RD)
        begin
            case (ADDR)
                viu_pkg::OFS_RAW_STAT: st_d.rdata = req;
                viu_pkg::OFS_ENABLE: st_d.rdata = st_q.enable;
                viu_pkg::OFS_SELECT: st_d.rdata = st_q.select;
                viu_pkg::OFS_FAST_STAT: st_d.rdata = fast_act; // RL4
                viu_pkg::OFS_NORM_STAT: st_d.rdata = act;
                viu_pkg::OFS_VECT_ADDR: st_d.rdata = st_q.vect; // RL8
                viu_pkg::OFS_P0_RISE: st_d.rdata = st_q.rise0;
                viu_pkg::OFS_P0_FALL: st_d.rdata = st_q.fall0;
                viu_pkg::OFS_P2_RISE: st_d.rdata = st_q.rise2;
                viu_pkg::OFS_P2_FALL: st_d.rdata = st_q.fall2;
                viu_pkg::OFS_P0_EDGE: st_d.rdata = st_q.edge0;
                viu_pkg::OFS_P2_EDGE: st_d.rdata = st_q.edge2;
                viu_pkg::OFS_EVT_STAT: st_d.rdata = {29'h0, st_q.evt_stat};
                viu_pkg::OFS_EVT_MASK: st_d.rdata = {29'h0, st_q.evt_mask};
                default:
                begin
                    if (ADDR[11:7] == viu_pkg::REGION_PRIO)
                    begin
                        st_d.rdata = {28'h0, st_q.prio[ADDR[6:2]]};
                    end
                end
            endcase
        end
        // read clears, but an event of the same cycle wins
        st_d.evt_stat = rd_stat ? viu_pkg::EVT_RST : st_q.evt_stat;
        st_d.evt_stat[viu_pkg::EVT_FAST] = st_d.evt_stat[viu_pkg::EVT_FAST] | (st_d.fast & ~st_q.fast);
        st_d.evt_stat[viu_pkg::EVT_NORM] = st_d.evt_stat[viu_pkg::EVT_NORM] | (st_d.norm & ~st_q.norm);
        st_d.evt_stat[viu_pkg::EVT_EDGE] = st_d.evt_stat[viu_pkg::EVT_EDGE] | (|hit0) | (|hit2);
        st_d.evt_irq = |(st_d.evt_stat & st_d.evt_mask);
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            st_q <= '0;
            st_q.prio <= {viu_pkg::NUM_SRC{viu_pkg::PRIO_RST}};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign RDATA = st_q.rdata;
    assign FAST_INTERRUPT_REQUEST = st_q.fast;
    assign IRQ_OUT = st_q.norm;
    assign EVT_IRQ = st_q.evt_irq;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    sequence s_norm_held;
        (|act)[*3];
    endsequence

    sequence s_no_winner;
        (!st_q.win_vld)[*2];
    endsequence

    a_sel_write_taken: assert property (WR && ADDR == viu_pkg::OFS_SELECT |=> st_q.select == $past(WDATA)) // RL1
        else $error("select write not taken");
    a_fast_never_wins: assert property (win_vld |-> !st_q.select[win_idx] && st_q.enable[win_idx]) // RL2
        else $error("fast or disabled channel won vectored selection");
    a_fast_or_out: assert property (##1 FAST_INTERRUPT_REQUEST == $past(|(req & st_q.enable & st_q.select))) // RL3
        else $error("fast output does not match its class");
    a_fast_stat_read: assert property (RD && ADDR == viu_pkg::OFS_FAST_STAT |=> RDATA == $past(fast_act)) // RL4
        else $error("fast status read wrong");
    a_lowest_prio_wins: assert property (win_vld |-> better == '0) // RL5
        else $error("a higher priority request lost");
    a_tie_low_chan: assert property (win_vld |-> (tie_cand & ((32'h1 << win_idx) - 32'h1)) == '0) // RL6
        else $error("tie not resolved to lowest channel");
    a_norm_or_out: assert property ((|act) != IRQ_OUT |=> IRQ_OUT == $past(|act)) // RL7
        else $error("normal output does not follow its class");
    a_vect_idle_zero: assert property (s_no_winner |=> st_q.vect == viu_pkg::WORD_RST) // RL8
        else $error("handler address not cleared without a winner");
    a_edge_caught: assert property (|hit0 |=> |st_q.edge0 ##0 req[viu_pkg::EXT3_CH]) // RL10
        else $error("port 0 edge not captured");
    a_edge_merged: assert property (|st_q.edge2 && st_q.enable[viu_pkg::EXT3_CH] |-> ##[1:2] (FAST_INTERRUPT_REQUEST || IRQ_OUT)) // RL11
        else $error("port 2 edge not merged into channel");
    a_level_holds: assert property (s_norm_held |-> IRQ_OUT) // RL12
        else $error("normal output dropped while request held");
    a_rdata_idle_zero: assert property (!RD |=> RDATA == viu_pkg::WORD_RST) // RL8
        else $error("read data not zero outside read cycle");
    a_vect_read_back: assert property (RD && ADDR == viu_pkg::OFS_VECT_ADDR |=> RDATA == $past(st_q.vect)) // RL8
        else $error("handler address read wrong");
endmodule : viu_vectored_interrupt_unit
`default_nettype wire

/* File: sim/viu_core_model.sv */
// core side: counts the requests it takes on its two interrupt inputs
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic fast_interrupt_request, // fast request from the unit
    input wire logic irq, // normal request from the unit
    output logic [7:0] fiq_cnt_q, // fast requests taken
    output logic [7:0] irq_cnt_q // normal requests taken
);
    logic fiq_q;
    logic irq_q;
    always @(posedge clk)
    begin
        fiq_q <= rst ? 1'b0 : fast_interrupt_request;
        irq_q <= rst ? 1'b0 : irq;
        if (rst)
        begin
            fiq_cnt_q <= 8'h00;
            irq_cnt_q <= 8'h00;
        end
        else
        begin
            fiq_cnt_q <= fiq_cnt_q + 8'(fast_interrupt_request && !fiq_q);
            irq_cnt_q <= irq_cnt_q + 8'(irq && !irq_q);
        end
    end
endmodule : viu_core_model
`default_nettype wire

/* File: sim/viu_vectored_interrupt_unit_tb_top.sv */
// self-checking bench of the vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module viu_vectored_interrupt_unit_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [31:0] rdata;
    logic [31:0] src = 32'h0;
    logic ext3 = 1'b0;
    logic [31:0] gpio0 = 32'h0;
    logic [31:0] gpio2 = 32'h0;
    logic fast_interrupt_request;
    logic irq;
    logic evt;
    logic [7:0] fiq_cnt;
    logic [7:0] irq_cnt;
    logic [31:0] exp_q[$];
    logic [31:0] sel;
    integer seed = 32'h14d3;
    integer num_errors = 0;
    integer checks = 0;
    integer cyc = 0;
    viu_vectored_interrupt_unit i_dut (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .IRQ_SRC(src), .EXT_INTERRUPT_LINE_THREE(ext3), .GPIO0(gpio0), .GPIO2(gpio2),
        .FAST_INTERRUPT_REQUEST(fast_interrupt_request), .IRQ_OUT(irq), .EVT_IRQ(evt));
    viu_core_model i_core (.clk(clk), .rst(rst), .fast_interrupt_request(fast_interrupt_request), .irq(irq), .fiq_cnt_q(fiq_cnt), .irq_cnt_q(irq_cnt));
    always #4 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic w(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : w
    task automatic r(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : r
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    // read data stand only in the cycle after the strobe, so compare there
    always @(posedge clk)
        rd_d <= rd;
    always @(negedge clk)
        if (rd_d)
            chk(rdata, exp_q.pop_front());
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        idle(6);
        rst <= 1'b0;
        r(viu_pkg::OFS_ENABLE, viu_pkg::WORD_RST);
        r(12'h200, 32'(viu_pkg::PRIO_RST));
        r(12'hFFC, 32'h0);
        w(viu_pkg::OFS_EVT_MASK, 32'h7);
        w(viu_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
        src <= 32'h1;
        idle(3);
        chk(32'(evt), 32'h1);
        r(viu_pkg::OFS_EVT_STAT, 32'h2);
        idle(2);
        chk(32'(evt), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            sel = $random(seed);
            w(viu_pkg::OFS_SELECT, sel);
            src <= $random(seed) & 32'hFFFD_FFFF;
            idle(3);
            chk(32'(fast_interrupt_request), 32'(|(src & sel)));
            chk(32'(irq), 32'(|(src & ~sel)));
            r(viu_pkg::OFS_FAST_STAT, src & sel);
            r(viu_pkg::OFS_NORM_STAT, src & ~sel);
        end
        w(viu_pkg::OFS_SELECT, 32'h0);
        src <= 32'h0;
        for (int n = 0; n < 32; n++)
            w(12'h100 + 12'(4 * n), 32'h1000 + 32'(n));
        src <= 32'h0000_0208;
        idle(5);
        r(viu_pkg::OFS_VECT_ADDR, 32'h1003);
        w(12'h224, 32'h1);
        idle(5);
        r(viu_pkg::OFS_VECT_ADDR, 32'h1009);
        w(viu_pkg::OFS_SELECT, 32'h200);
        idle(5);
        chk(32'(fast_interrupt_request), 32'h1);
        r(viu_pkg::OFS_VECT_ADDR, 32'h1003);
        w(viu_pkg::OFS_SELECT, 32'h0);
        src <= 32'h0;
        idle(5);
        r(viu_pkg::OFS_VECT_ADDR, 32'h0);
        w(viu_pkg::OFS_P0_RISE, 32'h10);
        gpio0 <= 32'h10;
        gpio2 <= 32'h80;
        idle(3);
        r(viu_pkg::OFS_P0_EDGE, 32'h10);
        r(viu_pkg::OFS_RAW_STAT, 32'h1 << viu_pkg::EXT3_CH);
        chk(32'(irq), 32'h1);
        w(viu_pkg::OFS_P0_EDGE, 32'h10);
        idle(1);
        r(viu_pkg::OFS_P0_EDGE, 32'h0);
        w(viu_pkg::OFS_P2_FALL, 32'h80);
        gpio2 <= 32'h0;
        idle(3);
        r(viu_pkg::OFS_P2_EDGE, 32'h80);
        w(viu_pkg::OFS_P2_EDGE, 32'h80);
        ext3 <= 1'b1;
        idle(3);
        r(viu_pkg::OFS_RAW_STAT, 32'h1 << viu_pkg::EXT3_CH);
        idle(3);
        chk(32'(fiq_cnt != 8'h00), 32'h1);
        chk(32'(irq_cnt != 8'h00), 32'h1);
        end_sim();
    end
endmodule : viu_vectored_interrupt_unit_tb_top
`default_nettype wire
